// [src/irq_entry.sv]
// interrupt sources, arbitration and entry stacking sequencer
// assumes the core sequencer drives the strobes on CLK and accepts one write a cycle
`timescale 1ns/10ps
`default_nettype none
module irq_entry
  import irq_pkg::*;
(
  input  wire logic                     CLK,
  input  wire logic                     NRST,
  input  wire logic [NUM_EXT-1:0]       EXT_EDGE_IN,
  input  wire logic [NUM_EXT-1:0]       EDGE_BOTH_SEL,
  input  wire logic [NUM_EXT-1:0]       EDGE_SENSE_SEL,
  input  wire logic                     SOURCE4_SEL,
  input  wire logic                     SOURCE5_SEL,
  input  wire logic                     SHARED_B3_SEL,
  input  wire logic                     SHARED_B4_SEL,
  input  wire logic                     SERIAL3_REQ,
  input  wire logic                     SERIAL4_REQ,
  input  wire logic                     TIMER_B3_REQ,
  input  wire logic                     TIMER_B4_REQ,
  input  wire logic                     UART0_COLL_REQ,
  input  wire logic                     UART1_COLL_REQ,
  input  wire logic [NUM_MASK-1:0]      PERIPH_REQ,
  input  wire logic [3*NUM_MASK-1:0]    REQ_LEVEL,
  input  wire logic [NUM_MASK-1:0]      FLAG_CLR,
  input  wire logic                     NMI_N,
  input  wire logic                     WDT_REQ,
  input  wire logic [NUM_KEY-1:0]       KEY_IN,
  input  wire logic [NUM_KEY-1:0]       KEY_DIR,
  input  wire logic [NUM_MATCH*ADDR_W-1:0] MATCH_ADDR,
  input  wire logic [NUM_MATCH-1:0]     MATCH_EN,
  input  wire logic [ADDR_W-1:0]        FETCH_ADDR,
  input  wire logic                     FETCH_LONG,
  input  wire logic                     SAMPLE,
  input  wire logic                     SWI,
  input  wire logic [5:0]               SWI_NUM,
  input  wire logic                     RETURN_REQ,
  input  wire ctx_t                     RETURN_CTX,
  input  wire ctx_t                     CUR_CTX,
  input  wire logic [ADDR_W-1:0]        INTERRUPT_STACK_POINTER,
  input  wire logic [ADDR_W-1:0]        USP,
  input  wire logic                     WR_READY,
  output wr_t                           WR,
  output logic                          ENTRY_DONE,
  output logic [5:0]                    VECTOR,
  output logic [2:0]                    NEW_IPL,
  output logic                          KEEP_U,
  output ctx_t                          RESTORE,
  output logic                          RESTORE_VALID,
  output logic [NUM_MASK-1:0]           REQ_FLAG,
  output logic                          NMI_PIN_LEVEL,
  output logic                          WAKE,
  output logic                          BUSY
);
  function automatic logic [NUM_EXT-1:0] edge_hit(input logic [NUM_EXT-1:0] cur,
      input logic [NUM_EXT-1:0] old, input logic [NUM_EXT-1:0] both,
      input logic [NUM_EXT-1:0] rise);
    edge_hit = (cur ^ old) & (both | (rise & cur) | (~rise & ~cur));
  endfunction : edge_hit

  logic [NUM_EXT-1:0] ext_s1_r, ext_s2_r, ext_old_r;
  logic [NUM_KEY-1:0] key_s1_r, key_s2_r;
  logic               nmi_s1_r, nmi_s2_r, nmi_old_r;
  logic               key_low_r;
  logic               nmi_pend_r, key_pend_r, wdt_pend_r, match_pend_r;
  logic [ADDR_W-1:0]  match_pc_r;
  ent_t               st_r;
  ctx_t               ctx_r;
  logic [ADDR_W-1:0]  sp_r;
  logic               odd_r;
  logic [NUM_MASK-1:0] flag_r;
  logic [NUM_EXT-1:0] ext_hit;
  logic [NUM_MASK-1:0] src_req;
  logic               win;
  logic [5:0]         win_idx;
  logic [2:0]         win_lvl;
  logic               key_low, match_hit, start;
  logic [5:0]         vec_nxt;
  logic [2:0]         ipl_nxt;
  logic [ADDR_W-1:0]  pc_save;
  logic [15:0]        word1, word2;

  // pins pass two flip-flops before any use
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ext_s1_r <= '1;
      ext_s2_r <= '1;
      ext_old_r <= '1;
      key_s1_r <= '1;
      key_s2_r <= '1;
      nmi_s1_r <= 1'b1;
      nmi_s2_r <= 1'b1;
      nmi_old_r <= 1'b1;
    end else begin
      ext_s1_r <= EXT_EDGE_IN;
      ext_s2_r <= ext_s1_r;
      ext_old_r <= ext_s2_r;
      key_s1_r <= KEY_IN;
      key_s2_r <= key_s1_r;
      nmi_s1_r <= NMI_N;
      nmi_s2_r <= nmi_s1_r;
      nmi_old_r <= nmi_s2_r;
    end
  end

  assign ext_hit = edge_hit(ext_s2_r, ext_old_r, EDGE_BOTH_SEL, EDGE_SENSE_SEL);

  // shared vector routing; slots 0..3 ext, 4..5 ext or serial, 6..7 timer or collision, rest peripheral
  always_comb begin
    src_req = PERIPH_REQ;
    src_req[3:0] = ext_hit[3:0];
    src_req[4] = SOURCE4_SEL ? ext_hit[4] : SERIAL3_REQ;
    src_req[5] = SOURCE5_SEL ? ext_hit[5] : SERIAL4_REQ;
    src_req[6] = SHARED_B3_SEL ? UART0_COLL_REQ : TIMER_B3_REQ;
    src_req[7] = SHARED_B4_SEL ? UART1_COLL_REQ : TIMER_B4_REQ;
  end

  // set wins over clear and acceptance
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      flag_r <= '0;
    end else begin
      for (int i = 0; i < NUM_MASK; i++) begin
        if (src_req[i])
          flag_r[i] <= 1'b1;
        else if (FLAG_CLR[i] || (start && !special_pick() && win_idx == 6'(i)))
          flag_r[i] <= 1'b0;
      end
    end
  end

  // only the first falling key counts
  assign key_low = |(~key_s2_r & ~KEY_DIR);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) key_low_r <= 1'b0;
    else key_low_r <= key_low;
  end

  always_comb begin
    match_hit = 1'b0;
    for (int i = 0; i < NUM_MATCH; i++)
      if (MATCH_EN[i] && MATCH_ADDR[i*ADDR_W +: ADDR_W] == FETCH_ADDR) match_hit = 1'b1;
  end

  // I flag, request flag and level vs priority
  irq_arbiter #(.N(NUM_MASK)) u_arb (
    .req     (flag_r & {NUM_MASK{CUR_CTX.flag_register[6]}}),
    .lvl     (REQ_LEVEL),
    .processor_priority_level     (CUR_CTX.flag_register[14:12]),
    .win     (win),
    .win_idx (win_idx),
    .win_lvl (win_lvl)
  );

  function automatic logic special_pick();
    special_pick = SWI || nmi_pend_r || wdt_pend_r || match_pend_r || key_pend_r;
  endfunction : special_pick

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      nmi_pend_r <= 1'b0;
      key_pend_r <= 1'b0;
      wdt_pend_r <= 1'b0;
      match_pend_r <= 1'b0;
      match_pc_r <= '0;
    end else begin
      if (nmi_old_r && !nmi_s2_r) nmi_pend_r <= 1'b1;
      else if (start && !SWI) nmi_pend_r <= 1'b0;
      if (WDT_REQ) wdt_pend_r <= 1'b1;
      else if (start && !SWI && !nmi_pend_r) wdt_pend_r <= 1'b0;
      if (match_hit) match_pend_r <= 1'b1;
      else if (start && !SWI && !nmi_pend_r && !wdt_pend_r) match_pend_r <= 1'b0;
      if (key_low && !key_low_r) key_pend_r <= 1'b1;
      // only the key pick clears it; a soft number equal to the key vector must not
      else if (start && !SWI && !nmi_pend_r && !wdt_pend_r && !match_pend_r)
        key_pend_r <= 1'b0;
      if (match_hit)
        match_pc_r <= FETCH_ADDR + ADDR_W'(FETCH_LONG ? PC_STEP_LONG : PC_STEP_SHRT);
    end
  end

  // fixed order: swi, nmi, watchdog, match, key, maskable
  always_comb begin
    vec_nxt = VEC_MASK0 + win_idx;
    ipl_nxt = win_lvl;
    if (SWI) begin
      vec_nxt = SWI_NUM;
      ipl_nxt = CUR_CTX.flag_register[14:12];
    end else if (nmi_pend_r) begin
      vec_nxt = VEC_NMI;
      ipl_nxt = LVL_SPECIAL;
    end else if (wdt_pend_r) begin
      vec_nxt = VEC_WDT;
      ipl_nxt = LVL_SPECIAL;
    end else if (match_pend_r) begin
      vec_nxt = VEC_MATCH;
      ipl_nxt = CUR_CTX.flag_register[14:12];
    end else if (key_pend_r) begin
      vec_nxt = VEC_KEY;
      ipl_nxt = win_lvl;
    end
  end

  assign start = (st_r == ST_IDLE) && SAMPLE && !RETURN_REQ && (special_pick() || win);
  assign pc_save = match_pend_r && !SWI && !nmi_pend_r && !wdt_pend_r ? match_pc_r : CUR_CTX.pc;

  assign word1 = {ctx_r.pc[ADDR_W-1:16], ctx_r.flag_register[15:12], ctx_r.flag_register[7:0]};
  assign word2 = ctx_r.pc[15:0];

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= ST_IDLE;
      ctx_r <= '0;
      sp_r <= '0;
      odd_r <= 1'b0;
      VECTOR <= 6'h00;
      NEW_IPL <= LVL_ZERO;
      KEEP_U <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: if (start) begin
          ctx_r <= '{pc: pc_save, flag_register: CUR_CTX.flag_register, bank: CUR_CTX.bank};
          VECTOR <= vec_nxt;
          NEW_IPL <= ipl_nxt;
          KEEP_U <= SWI && SWI_NUM >= SWI_LO && SWI_NUM <= SWI_HI;
          sp_r <= (SWI && SWI_NUM >= SWI_LO && CUR_CTX.flag_register[7]) ? USP : INTERRUPT_STACK_POINTER;
          odd_r <= (SWI && SWI_NUM >= SWI_LO && CUR_CTX.flag_register[7]) ? USP[0] : INTERRUPT_STACK_POINTER[0];
          st_r <= ST_W1A;
        end
        ST_W1A: if (WR_READY) st_r <= odd_r ? ST_W1B : ST_W2A;
        ST_W1B: if (WR_READY) st_r <= ST_W2A;
        ST_W2A: if (WR_READY) st_r <= odd_r ? ST_W2B : ST_DONE;
        ST_W2B: if (WR_READY) st_r <= ST_DONE;
        ST_DONE: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // stack grows down: word one sits above word two
  always_comb begin
    WR = '0;
    case (st_r)
      ST_W1A: WR = '{valid: 1'b1, wide: !odd_r, addr: sp_r - ADDR_W'(2),
                     data: odd_r ? {8'h00, word1[15:8]} : word1};
      ST_W1B: WR = '{valid: 1'b1, wide: 1'b0, addr: sp_r - ADDR_W'(3),
                     data: {8'h00, word1[7:0]}};
      ST_W2A: WR = '{valid: 1'b1, wide: !odd_r, addr: sp_r - ADDR_W'(4),
                     data: odd_r ? {8'h00, word2[15:8]} : word2};
      ST_W2B: WR = '{valid: 1'b1, wide: 1'b0, addr: sp_r - ADDR_W'(5),
                     data: {8'h00, word2[7:0]}};
      default: WR = '0;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RESTORE <= '0;
      RESTORE_VALID <= 1'b0;
    end else begin
      RESTORE_VALID <= RETURN_REQ && st_r == ST_IDLE;
      if (RETURN_REQ && st_r == ST_IDLE) RESTORE <= RETURN_CTX;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      NMI_PIN_LEVEL <= 1'b1;
      WAKE <= 1'b0;
    end else begin
      NMI_PIN_LEVEL <= nmi_s2_r;
      WAKE <= key_pend_r || nmi_pend_r;
    end
  end

  assign ENTRY_DONE = st_r == ST_DONE;
  assign BUSY = st_r != ST_IDLE;
  assign REQ_FLAG = flag_r;
endmodule : irq_entry
`default_nettype wire

// [src/irq_pkg.sv]
// package for the interrupt entry and source block
// assumes one 200 MHz clock domain and no register bus
package irq_pkg;
  localparam int          NUM_EXT      = 6;
  localparam int          NUM_KEY      = 4;
  localparam int          NUM_MATCH    = 4;
  localparam int          NUM_MASK     = 16;
  localparam int          ADDR_W       = 20;
  localparam logic [2:0]  LVL_SPECIAL  = 3'h7;
  localparam logic [2:0]  LVL_ZERO     = 3'h0;
  localparam logic [5:0]  SWI_LO       = 6'h20;
  localparam logic [5:0]  SWI_HI       = 6'h3F;
  localparam logic [5:0]  VEC_NMI      = 6'h39;
  localparam logic [5:0]  VEC_WDT      = 6'h3A;
  localparam logic [5:0]  VEC_MATCH    = 6'h3B;
  localparam logic [5:0]  VEC_KEY      = 6'h3C;
  localparam logic [5:0]  VEC_MASK0    = 6'h00;
  localparam logic [2:0]  PC_HI_LSB    = 3'h0;
  localparam logic [1:0]  PC_STEP_LONG = 2'h2;
  localparam logic [1:0]  PC_STEP_SHRT = 2'h1;
  localparam logic [15:0] RST_WORD     = 16'h0000;

  typedef struct packed {
    logic [ADDR_W-1:0] pc;
    logic [15:0]       flag_register;
    logic [1:0]        bank;
  } ctx_t;

  typedef struct packed {
    logic              valid;
    logic              wide;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } wr_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_W1A  = 6'b000010,
    ST_W1B  = 6'b000100,
    ST_W2A  = 6'b001000,
    ST_W2B  = 6'b010000,
    ST_DONE = 6'b100000
  } ent_t;
endpackage : irq_pkg

// [src/irq_arbiter.sv]
// fixed-rank arbiter over maskable requests
// assumes requests and levels come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module irq_arbiter
  import irq_pkg::*;
#(
  parameter int N = NUM_MASK
) (
  input  wire logic [N-1:0]   req,
  input  wire logic [3*N-1:0] lvl,
  input  wire logic [2:0]     processor_priority_level,
  output logic                win,
  output logic [5:0]          win_idx,
  output logic [2:0]          win_lvl
);
  // lower index ranks higher among equals
  always_comb begin
    win     = 1'b0;
    win_idx = 6'h00;
    win_lvl = LVL_ZERO;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && lvl[3*i +: 3] > processor_priority_level && (!win || lvl[3*i +: 3] >= win_lvl)) begin
        win     = 1'b1;
        win_idx = 6'(i);
        win_lvl = lvl[3*i +: 3];
      end
    end
  end
endmodule : irq_arbiter
`default_nettype wire

// [bench/irq_entry_checker.sv]
// port checker for the interrupt entry block
// assumes one clock domain and a bind from tb_top
`timescale 1ns/10ps
`default_nettype none
module irq_entry_checker
  import irq_pkg::*;
(
  input wire logic              CLK,
  input wire logic              NRST,
  input wire logic              SAMPLE,
  input wire logic              SWI,
  input wire logic [5:0]        SWI_NUM,
  input wire logic              RETURN_REQ,
  input wire ctx_t              RETURN_CTX,
  input wire ctx_t              CUR_CTX,
  input wire logic [ADDR_W-1:0] INTERRUPT_STACK_POINTER,
  input wire logic [ADDR_W-1:0] USP,
  input wire logic              WR_READY,
  input wire logic              NMI_N,
  input wire wr_t               WR,
  input wire logic              ENTRY_DONE,
  input wire logic [5:0]        VECTOR,
  input wire logic              KEEP_U,
  input wire ctx_t              RESTORE,
  input wire logic              RESTORE_VALID,
  input wire logic              NMI_PIN_LEVEL,
  input wire logic              BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  chk_done_one_cycle: assert property (ENTRY_DONE |=> !ENTRY_DONE)
    else $error("entry done held longer than one cycle");
  chk_stack_select: assert property ($rose(WR.valid) |-> WR.addr ==
    ((KEEP_U && $past(CUR_CTX.flag_register[7])) ? $past(USP) : $past(INTERRUPT_STACK_POINTER)) - 20'h2)
    else $error("first stack write at wrong address");
  chk_width_by_sp: assert property ($rose(WR.valid) |-> WR.wide == !WR.addr[0])
    else $error("write width does not follow pointer parity");
  chk_first_word: assert property ($rose(WR.valid) && WR.wide |-> WR.data ==
    {$past(CUR_CTX.pc[19:16]), $past(CUR_CTX.flag_register[15:12]), $past(CUR_CTX.flag_register[7:0])})
    else $error("first stacked word wrong");
  chk_word_step: assert property ($rose(WR.valid) && WR.wide && WR_READY |=>
    WR.valid && WR.wide && WR.addr == $past(WR.addr) - 20'h2)
    else $error("second word not two below first");
  chk_byte_step: assert property ($rose(WR.valid) && !WR.wide && WR_READY |=>
    WR.valid && !WR.wide && WR.addr == $past(WR.addr) - 20'h1)
    else $error("byte writes not descending");
  chk_return_ctx: assert property (RETURN_REQ && !BUSY |=>
    RESTORE_VALID && RESTORE == $past(RETURN_CTX))
    else $error("restored context differs");
  chk_swi_branch: assert property (SAMPLE && SWI && !BUSY && !RETURN_REQ |=>
    WR.valid && VECTOR == $past(SWI_NUM))
    else $error("software interrupt not taken");
  chk_nmi_level: assert property (NMI_N == $past(NMI_N) &&
    $past(NMI_N) == $past(NMI_N, 2) && $past(NMI_N, 2) == $past(NMI_N, 3)
    |-> NMI_PIN_LEVEL == NMI_N)
    else $error("nmi pin level not reflected");
endmodule : irq_entry_checker
`default_nettype wire

// [bench/irq_pins.sv]
// model of the external pins facing the block
// assumes the bench calls its tasks off the clock edge
`timescale 1ns/10ps
`default_nettype none
module irq_pins
  import irq_pkg::*;
(
  output var logic               NMI_N,
  output var logic [NUM_KEY-1:0] KEY_IN,
  output var logic [NUM_EXT-1:0] EXT_EDGE_IN
);
  // pins rest high, as the board pull-ups hold them
  initial begin
    NMI_N = 1'h1;
    KEY_IN = 4'hF;
    EXT_EDGE_IN = 6'h3F;
  end
  // nmi pin driven low to request
  task automatic nmi(input logic lvl);
    NMI_N = lvl;
  endtask : nmi
  // key press pulls the pin low
  task automatic key(input int i, input logic lvl);
    KEY_IN[i] = lvl;
  endtask : key
  task automatic ext(input int i, input logic lvl);
    EXT_EDGE_IN[i] = lvl;
  endtask : ext
endmodule : irq_pins
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the interrupt entry block
// assumes the core always accepts writes at once
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import irq_pkg::*;
  logic CLK = 1'h0, NRST = 1'h0;
  logic SOURCE4_SEL, SOURCE5_SEL, SHARED_B3_SEL, SHARED_B4_SEL, SERIAL3_REQ, SERIAL4_REQ;
  logic TIMER_B3_REQ, TIMER_B4_REQ, UART0_COLL_REQ, UART1_COLL_REQ, WDT_REQ, FETCH_LONG;
  logic SAMPLE, SWI, RETURN_REQ, WR_READY, NMI_N, ENTRY_DONE, KEEP_U, RESTORE_VALID;
  logic NMI_PIN_LEVEL, WAKE, BUSY;
  logic [5:0] EXT_EDGE_IN, EDGE_BOTH_SEL, EDGE_SENSE_SEL, SWI_NUM, VECTOR;
  logic [15:0] PERIPH_REQ, FLAG_CLR, REQ_FLAG;
  logic [47:0] REQ_LEVEL;
  logic [3:0] KEY_IN, KEY_DIR, MATCH_EN;
  logic [79:0] MATCH_ADDR;
  logic [19:0] FETCH_ADDR, INTERRUPT_STACK_POINTER, USP;
  logic [2:0] NEW_IPL;
  ctx_t RETURN_CTX, CUR_CTX, RESTORE;
  wr_t WR;
  logic [19:0] wa [4];
  logic [15:0] wd [4];
  int nwr, err_total = 0, checks_done = 0;
  irq_entry u_dut (.*);
  irq_pins u_pins (.NMI_N(NMI_N), .KEY_IN(KEY_IN), .EXT_EDGE_IN(EXT_EDGE_IN));
  always #2.5 CLK = ~CLK;
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask : tick
  task automatic clr;
    FLAG_CLR = 16'hFFFF;
    tick(1);
    FLAG_CLR = 16'h0000;
  endtask : clr
  // one sampling point; gathers the stacked writes, bounded wait
  task automatic enter(input logic sw);
    int k;
    nwr = 0;
    SAMPLE = 1'h1;
    SWI = sw;
    tick(1);
    SAMPLE = 1'h0;
    SWI = 1'h0;
    for (k = 0; k < 8 && !ENTRY_DONE; k++) begin
      if (WR.valid && nwr < 4) begin
        wa[nwr] = WR.addr;
        wd[nwr] = WR.data;
        nwr++;
      end
      tick(1);
    end
    if (nwr > 0 && ENTRY_DONE !== 1'h1) begin
      err_total++;
      end_sim();
    end
    tick(1);
  endtask : enter
  task automatic s_swi;
    CUR_CTX = '{20'hA1234, 16'h70C5, 2'h1};
    SWI_NUM = 6'h21;
    enter(1'h1);
    check(nwr, 4);
    check(KEEP_U, 1'h1);
    check(wa[0], 20'h003FF);
    check(wa[3], 20'h003FC);
    SWI_NUM = 6'h05;
    enter(1'h1);
    check(wa[0], 20'h007FE);
    check(KEEP_U, 1'h0);
    check({wd[0], wd[1]}, 32'hA7C51234);
    check(VECTOR, 6'h05);
  endtask : s_swi
  task automatic s_mask;
    REQ_LEVEL = 48'h00002D000003;
    CUR_CTX.flag_register = 16'h2085;
    u_pins.ext(0, 1'h0);
    PERIPH_REQ = 16'h0300;
    tick(1);
    PERIPH_REQ = 16'h0000;
    tick(4);
    check(REQ_FLAG, 16'h0301);
    enter(1'h0);
    check(nwr, 0);
    CUR_CTX.flag_register = 16'h20C5;
    enter(1'h0);
    check(REQ_FLAG, 16'h0201);
    check(NEW_IPL, 3'h5);
    CUR_CTX.flag_register = 16'h50C5;
    enter(1'h0);
    check(nwr, 0);
    clr();
    u_pins.ext(0, 1'h1);
    // falling sense left set, yet both edges flag the pin while both edges chosen
    EDGE_BOTH_SEL = 6'h02;
    u_pins.ext(1, 1'h0);
    tick(4);
    check(REQ_FLAG, 16'h0002);
    clr();
    u_pins.ext(1, 1'h1);
    tick(4);
    check(REQ_FLAG, 16'h0002);
    clr();
  endtask : s_mask
  task automatic s_share;
    SERIAL3_REQ = 1'h1;
    SERIAL4_REQ = 1'h1;
    TIMER_B4_REQ = 1'h1;
    UART0_COLL_REQ = 1'h1;
    tick(1);
    {SERIAL3_REQ, SERIAL4_REQ, TIMER_B4_REQ, UART0_COLL_REQ} = 4'h0;
    tick(2);
    check(REQ_FLAG, 16'h00B0);
    SOURCE4_SEL = 1'h1;
    SHARED_B3_SEL = 1'h1;
    // stale flags dropped after a select change
    clr();
    {SERIAL3_REQ, TIMER_B3_REQ, UART0_COLL_REQ} = 3'h7;
    u_pins.ext(4, 1'h0);
    tick(1);
    {SERIAL3_REQ, TIMER_B3_REQ, UART0_COLL_REQ} = 3'h0;
    tick(4);
    check(REQ_FLAG, 16'h0050);
    u_pins.ext(4, 1'h1);
    tick(4);
    clr();
  endtask : s_share
  task automatic s_special;
    CUR_CTX.flag_register = 16'h7005;
    u_pins.nmi(1'h0);
    WDT_REQ = 1'h1;
    tick(1);
    WDT_REQ = 1'h0;
    tick(3);
    check(NMI_PIN_LEVEL, 1'h0);
    enter(1'h0);
    check(VECTOR, VEC_NMI);
    check(NEW_IPL, LVL_SPECIAL);
    enter(1'h0);
    check(VECTOR, VEC_WDT);
    u_pins.nmi(1'h1);
  endtask : s_special
  task automatic s_match;
    int j;
    MATCH_ADDR[59:40] = 20'hA0100;
    for (j = 1; j >= 0; j--) begin
      MATCH_EN = 4'h4;
      FETCH_ADDR = 20'hA0100;
      FETCH_LONG = j[0];
      tick(1);
      enter(1'h0);
      check(VECTOR, VEC_MATCH);
      check(wd[1], j ? 16'h0102 : 16'h0101);
      MATCH_EN = 4'h0;
      FETCH_ADDR = 20'h00000;
      tick(2);
      enter(1'h0);
    end
    FETCH_ADDR = 20'hA0100;
    tick(2);
    enter(1'h0);
    check(nwr, 0);
    FETCH_ADDR = 20'h00000;
  endtask : s_match
  task automatic s_key;
    KEY_DIR = 4'h4;
    u_pins.key(2, 1'h0);
    tick(4);
    enter(1'h0);
    check(nwr, 0);
    u_pins.key(2, 1'h1);
    tick(4);
    KEY_DIR = 4'h0;
    u_pins.key(0, 1'h0);
    tick(4);
    check(WAKE, 1'h1);
    enter(1'h0);
    check(VECTOR, VEC_KEY);
    u_pins.key(1, 1'h0);
    tick(4);
    enter(1'h0);
    check(nwr, 0);
  endtask : s_key
  task automatic s_ret;
    // software hands back a corrected return address
    RETURN_CTX = '{20'hA0100, 16'h30C1, 2'h2};
    RETURN_REQ = 1'h1;
    tick(1);
    RETURN_REQ = 1'h0;
    check(RESTORE_VALID, 1'h1);
    check(RESTORE, RETURN_CTX);
  endtask : s_ret
  initial begin
    // source selects start at the serial units, shared selects at the timers
    {SOURCE4_SEL, SOURCE5_SEL, SHARED_B3_SEL, SHARED_B4_SEL, SERIAL3_REQ, SERIAL4_REQ} = 6'h00;
    {TIMER_B3_REQ, TIMER_B4_REQ, UART0_COLL_REQ, UART1_COLL_REQ, WDT_REQ, FETCH_LONG} = 6'h00;
    {SAMPLE, SWI, RETURN_REQ, PERIPH_REQ, FLAG_CLR, EDGE_BOTH_SEL, EDGE_SENSE_SEL} = '0;
    {SWI_NUM, MATCH_EN, MATCH_ADDR, FETCH_ADDR, RETURN_CTX, CUR_CTX, REQ_LEVEL} = '0;
    KEY_DIR = 4'hF;
    INTERRUPT_STACK_POINTER = 20'h00800;
    USP = 20'h00401;
    WR_READY = 1'h1;
    tick(16);
    NRST = 1'h1;
    tick(2);
    check(REQ_FLAG, 16'h0000);
    check(NMI_PIN_LEVEL, 1'h1);
    s_swi();
    s_mask();
    s_share();
    s_special();
    s_match();
    s_key();
    s_ret();
    end_sim();
  end
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
endmodule : tb_top
bind irq_entry irq_entry_checker u_chk (.*);
`default_nettype wire
